// [dv/bqa_alloc_model.sv]
// Purpose: Allocation source standing in for the bus in-order queue
// Assumes: One clock, synchronous active-high reset
// Notes:   Qualifiers scramble between bursts so nothing stale matches
`timescale 1ns/1ps
`default_nettype none
module bqa_alloc_model (
	input  wire logic        sys_clk,   // Core clock
	input  wire logic        rst,       // Sync reset
	input  wire logic        go,        // Start a burst
	input  wire logic [3:0]  burst,     // Allocations in the burst
	input  wire logic [13:0] fields,    // Packed qualifiers
	output logic             alloc_vld, // Allocation strobe
	output logic      [4:0]  req_type,  // Request type
	output logic             is_read,   // Read class
	output logic             is_write,  // Write class
	output logic      [4:0]  mem_type,  // One-hot memory type
	output logic             own_agent, // Own processor
	output logic             prefetch   // Prefetch sector
);
	logic [3:0]  rem;      // Allocations still to send
	logic [3:0]  next_rem;
	logic        next_vld;
	logic [13:0] q;        // Qualifiers on the wires
	logic [13:0] next_q;

	// Burst sequencing; idle qualifiers invert each cycle
	always_comb begin
		next_rem = rem;
		next_vld = alloc_vld;
		next_q   = q;
		if (go) begin
			next_vld = 1'b1;
			next_rem = burst - 4'h1;
			next_q   = fields;
		end else if (rem != 4'h0) begin
			next_rem = rem - 4'h1;
		end else begin
			// Released: a stale value must not pass for valid data
			next_vld = 1'b0;
			next_q   = ~q;
		end
	end

	// State registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rem       <= 4'h0;
			alloc_vld <= 1'b0;
			q         <= 14'h0;
		end else begin
			rem       <= next_rem;
			alloc_vld <= next_vld;
			q         <= next_q;
		end
	end

	assign {req_type, is_read, is_write, mem_type, own_agent, prefetch} = q;
endmodule : bqa_alloc_model
`default_nettype wire

// [dv/bus_queue_alloc_event_matcher_tb.sv]
// Purpose: Self-checking bench for the allocation event matcher
// Assumes: APB answers after one wait state, pulse one cycle later
// Notes:   Case word is {mask, model, req, rd, wr, mem, own, pf}
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) \
	begin err_total++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", \
	$time, (got), (exp)); end end
module bus_queue_alloc_event_matcher_tb;
	logic        sys_clk = 1'b0;  // 100 ns period
	logic        rst = 1'b1;      // Sync reset
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, rerr, go = 1'b0, alloc_vld;
	logic        is_read, is_write, own_agent, prefetch;
	logic [3:0]  burst = 4'h1, cnt_pulse;
	logic [13:0] fields = 14'h0;
	logic [4:0]  req_type, mem_type;
	int          err_total = 0, samples_checked = 0;
	localparam logic [33:0] CASES [11] = '{
		{16'h2001, 4'h0, 5'h01, 2'b01, 5'h10, 2'b10},
		{16'h4080, 4'h0, 5'h02, 2'b01, 5'h01, 2'b00},
		{16'h4080, 4'h0, 5'h02, 2'b01, 5'h01, 2'b10},
		{16'h20a0, 4'h0, 5'h02, 2'b01, 5'h01, 2'b10},
		{16'h2020, 4'h0, 5'h02, 2'b10, 5'h01, 2'b11},
		{16'ha020, 4'h0, 5'h02, 2'b10, 5'h01, 2'b11},
		{16'h2040, 4'h0, 5'h02, 2'b01, 5'h01, 2'b11},
		{16'h2841, 4'h2, 5'h01, 2'b01, 5'h10, 2'b10},
		{16'h2841, 4'h2, 5'h01, 2'b01, 5'h01, 2'b10},
		{16'h2841, 4'h3, 5'h02, 2'b01, 5'h10, 2'b10},
		{16'h2841, 4'h2, 5'h01, 2'b10, 5'h10, 2'b10}};

	always #50 sys_clk = ~sys_clk;

	bqa_top uut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .alloc_vld(alloc_vld), .req_type(req_type),
		.is_read(is_read), .is_write(is_write), .mem_type(mem_type),
		.own_agent(own_agent), .prefetch(prefetch), .cnt_pulse(cnt_pulse));
	bqa_alloc_model src (.sys_clk(sys_clk), .rst(rst), .go(go),
		.burst(burst), .fields(fields), .alloc_vld(alloc_vld),
		.req_type(req_type), .is_read(is_read), .is_write(is_write),
		.mem_type(mem_type), .own_agent(own_agent), .prefetch(prefetch));

	// One APB transfer; only the watchdog ends a hung wait
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk) penable <= 1'b1;
		do @(posedge sys_clk);
		while (pready !== 1'b1);
		// Answer taken at the edge that samples pready high
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next setup never re-raises psel at once
		@(posedge sys_clk);
	endtask : apb

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask : rd_chk

	// Burst of n allocations, pulses checked each cycle
	task automatic alloc(input logic [3:0] n, input logic [13:0] f,
		input logic [3:0] e0, input logic [3:0] e1);
		go <= 1'b1; burst <= n; fields <= f;
		@(posedge sys_clk) go <= 1'b0;
		@(posedge sys_clk);
		for (int k = 0; k < n; k++) begin
			@(posedge sys_clk);
			`CHK(cnt_pulse, (k == 0) ? e0 : e1)
		end
	endtask : alloc

	// Reference match worked out from the mask rules
	function automatic logic exp_hit(input logic [33:0] c);
		logic rq, rw, mt, src;
		rq  = c[22:18] == c[13:9];
		rw  = (c[23] & c[8]) | (c[24] & c[7]);
		mt  = |(c[29:25] & c[6:2]);
		src = (c[31] & c[1]) | (c[32] & ~c[1]);
		if (c[8] & c[0] & ~c[33]) return 1'b0;
		if (c[17:14] >= bqa_pkg::MODEL_AND) return rq & rw & mt & src;
		if (c[23] | c[24]) return (rq | rw) & src;
		return (rq | mt) & src;
	endfunction : exp_hit

	task automatic run_case(input logic [33:0] c);
		logic h;
		h = exp_hit(c);
		apb(1'b1, bqa_pkg::OFS_SEL_A, {bqa_pkg::SEL_CODE, c[33:18], 9'h0});
		apb(1'b1, bqa_pkg::OFS_MODEL, {28'h0, c[17:14]});
		alloc(4'h1, c[13:0], {2'b00, h, h}, 4'h0);
	endtask : run_case

	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (4000) @(posedge sys_clk);
		err_total++;
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd_chk(bqa_pkg::OFS_MODEL, 32'h0);
		rd_chk(bqa_pkg::OFS_CFG_A, bqa_pkg::RST_CFG);
		apb(1'b1, bqa_pkg::OFS_CFG_A, 32'h0000_c000);
		rd_chk(bqa_pkg::OFS_CFG_A, 32'h0000_c000);
		$display("reset and config test done");
		foreach (CASES[i]) run_case(CASES[i]);
		$display("match table test done");
		for (int j = 0; j < 5; j++) begin
			run_case({16'h2000 | (16'h0080 << j), 4'h0, 5'h01, 2'b01,
				5'h01 << j, 2'b10});
			run_case({16'h2000 | (16'h0080 << j), 4'h0, 5'h01, 2'b01,
				5'h01 << ((j + 1) % 5), 2'b10});
		end
		$display("memory type test done");
		apb(1'b1, bqa_pkg::OFS_SEL_A, {7'h03, 16'h2001, 9'h0});
		apb(1'b1, bqa_pkg::OFS_SEL_B, {7'h03, 16'h2001, 9'h0});
		apb(1'b1, bqa_pkg::OFS_CFG_B, 32'h0000_c000);
		alloc(4'h1, {5'h01, 2'b01, 5'h01, 2'b10}, 4'hf, 4'h0);
		apb(1'b1, bqa_pkg::OFS_SEL_A, {7'h0c, 16'h2001, 9'h0});
		alloc(4'h1, {5'h01, 2'b01, 5'h01, 2'b10}, 4'hc, 4'h0);
		$display("counter routing test done");
		apb(1'b1, bqa_pkg::OFS_SEL_A, {7'h03, 16'h2001, 9'h0});
		apb(1'b1, bqa_pkg::OFS_CFG_A, 32'h0000_c001);
		alloc(4'h3, {5'h01, 2'b01, 5'h01, 2'b10}, 4'hf, 4'hc);
		apb(1'b1, bqa_pkg::OFS_STAT, 32'h0000_000f);
		rd_chk(bqa_pkg::OFS_STAT, 32'h0);
		alloc(4'h1, {5'h01, 2'b01, 5'h01, 2'b10}, 4'hf, 4'h0);
		rd_chk(bqa_pkg::OFS_STAT, 32'h0000_000f);
		$display("edge and status test done");
		rd_chk(12'h018, 32'h0);
		`CHK(rerr, 1'b1)
		$display("unmapped access test done");
		give_verdict();
	end
endmodule : bus_queue_alloc_event_matcher_tb
`default_nettype wire

// [src/bqa_match.sv]
// Purpose: Combinational match of one allocation against one mask
// Assumes: Memory type and request type arrive one-hot / coded
// Notes:   Pure logic, no state; instantiated per event select
`timescale 1ns/1ps
`default_nettype none
module bqa_match (
	input  wire logic [15:0] mask,      // Event mask field
	input  wire logic        and_form,  // Model encoding two or above
	input  wire logic [4:0]  req_type,  // Allocated request type
	input  wire logic        is_read,   // Read class
	input  wire logic        is_write,  // Write class
	input  wire logic [4:0]  mem_type,  // One-hot memory type
	input  wire logic        own_agent, // Issued by this processor
	input  wire logic        prefetch,  // Prefetch sector
	output logic             hit        // Allocation qualifies
);
	logic req_m;   // Request-type term
	logic rw_m;    // All-reads / all-writes term
	logic mem_m;   // Memory-type term
	logic src_m;   // Source-agent term
	logic pf_ok;   // Prefetch admission

	// ----------------------------------------------------------------
	// Terms
	// ----------------------------------------------------------------
	always_comb begin
		req_m = (req_type == mask[bqa_pkg::M_REQ_LO +: 5]);
		rw_m  = (mask[bqa_pkg::M_ALL_RD] & is_read) |
			(mask[bqa_pkg::M_ALL_WR] & is_write);
		mem_m = |(mask[bqa_pkg::M_MEM_LO +: 5] & mem_type);
		src_m = (mask[bqa_pkg::M_OWN] & own_agent) |
			(mask[bqa_pkg::M_OTHER] & ~own_agent);
		pf_ok = ~(is_read & prefetch) | mask[bqa_pkg::M_PREFETCH];
		if (and_form) begin
			hit = req_m & rw_m & mem_m & src_m & pf_ok;
		end else if (mask[bqa_pkg::M_ALL_RD] | mask[bqa_pkg::M_ALL_WR]) begin
			hit = (req_m | rw_m) & src_m & pf_ok;
		end else begin
			hit = (req_m | mem_m) & src_m & pf_ok;
		end
	end
endmodule : bqa_match
`default_nettype wire

// [src/bqa_pkg.sv]
// Purpose: Shared constants for the queue allocation event matcher
// Assumes: Event-select word layout with mask in bits 24:9
// Notes:   Register map is a local choice, one aligned word each
package bqa_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets on APB
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_SEL_A  = 12'h000; // Event select a
	localparam logic [11:0] OFS_SEL_B  = 12'h004; // Event select b
	localparam logic [11:0] OFS_CFG_A  = 12'h008; // Counter config a
	localparam logic [11:0] OFS_CFG_B  = 12'h00c; // Counter config b
	localparam logic [11:0] OFS_MODEL  = 12'h010; // Model encoding
	localparam logic [11:0] OFS_STAT   = 12'h014; // Match status
	// ----------------------------------------------------------------
	// Event select word fields
	// ----------------------------------------------------------------
	localparam int          SEL_CODE_LO = 25;      // Code bits 31:25
	localparam logic [6:0]  SEL_CODE    = 7'h03;   // Queue alloc event
	localparam int          MASK_LO     = 9;       // Mask bits 24:9
	localparam int          CFG_SEL_LO  = 13;      // Config bits 15:13
	localparam logic [2:0]  CFG_SEL     = 3'h6;    // Bus config group
	localparam int          CFG_EDGE    = 0;       // Edge-trigger bit
	// ----------------------------------------------------------------
	// Mask field positions
	// ----------------------------------------------------------------
	localparam int          M_REQ_LO    = 0;       // Request type 4:0
	localparam int          M_ALL_RD    = 5;
	localparam int          M_ALL_WR    = 6;
	localparam int          M_MEM_LO    = 7;       // Memory types 11:7
	localparam int          M_OWN       = 13;
	localparam int          M_OTHER     = 14;
	localparam int          M_PREFETCH  = 15;
	localparam logic [4:0]  REQ_DEFAULT = 5'h01;   // Invalid or default
	localparam logic [3:0]  MODEL_AND   = 4'h2;    // AND form from here
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_SEL     = 32'h0000_0000;
	localparam logic [31:0] RST_CFG     = 32'h0000_0000;
	localparam logic [3:0]  RST_MODEL   = 4'h0;
endpackage : bqa_pkg

// [src/bqa_top.sv]
// What this block does
// - Bits 13/14 select own or other agent
// - Model two up ANDs all four terms
// - Bits 4:0 one request-type field, default 00001
// - Bits 7 to 11 select memory types
// - Prefetch clear excludes prefetched read sectors
// - Model encoding picks OR or AND form
// - All-reads/writes make legacy ignore memory bits
//
// Purpose: Qualify queue allocations and pulse four counter inputs
// Assumes: APB slave, one clock, synchronous active-high reset
// Notes:   Allocation inputs come from same-clock logic, no sync
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module bqa_top (
	input  wire logic        sys_clk,    // 10 MHz core clock
	input  wire logic        rst,        // Sync reset, active high
	input  wire logic        psel,       // APB select
	input  wire logic        penable,    // APB access phase
	input  wire logic        pwrite,     // APB direction
	input  wire logic [11:0] paddr,      // APB byte address
	input  wire logic [31:0] pwdata,     // APB write data
	output logic      [31:0] prdata,     // APB read data
	output logic             pready,     // APB ready
	output logic             pslverr,    // APB error
	input  wire logic        alloc_vld,  // Allocation strobe
	input  wire logic [4:0]  req_type,   // Request type
	input  wire logic        is_read,    // Read class
	input  wire logic        is_write,   // Write class
	input  wire logic [4:0]  mem_type,   // One-hot memory type
	input  wire logic        own_agent,  // Own processor request
	input  wire logic        prefetch,   // Prefetch sector
	output logic      [3:0]  cnt_pulse   // Count pulses, counters 0-3
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0] sel_a, sel_b, next_sel_a, next_sel_b;   // Event selects
	logic [31:0] cfg_a, cfg_b, next_cfg_a, next_cfg_b;   // Counter configs
	logic [3:0]  model, next_model;                      // Model encoding
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr;
	logic [3:0]  next_cnt_pulse;
	logic [1:0]  hit_prev, next_hit_prev;   // Previous hit for edges
	logic [3:0]  match_seen, next_match_seen; // Sticky status
	logic [1:0]  hit;                        // Raw matches a, b
	logic [1:0]  armed;                      // Selector codes correct
	logic [1:0]  edge_mode;                  // Edge-trigger chosen
	logic        and_form;
	logic        access;                     // Access phase, unanswered
	logic        mapped;

	assign and_form = (model >= bqa_pkg::MODEL_AND);

	// ----------------------------------------------------------------
	// Matchers, one per event select
	// ----------------------------------------------------------------
	bqa_match u_match_a (
		.mask      (sel_a[bqa_pkg::MASK_LO +: 16]),
		.and_form  (and_form),
		.req_type  (req_type),
		.is_read   (is_read),
		.is_write  (is_write),
		.mem_type  (mem_type),
		.own_agent (own_agent),
		.prefetch  (prefetch),
		.hit       (hit[0])
	);
	bqa_match u_match_b (
		.mask      (sel_b[bqa_pkg::MASK_LO +: 16]),
		.and_form  (and_form),
		.req_type  (req_type),
		.is_read   (is_read),
		.is_write  (is_write),
		.mem_type  (mem_type),
		.own_agent (own_agent),
		.prefetch  (prefetch),
		.hit       (hit[1])
	);

	// ----------------------------------------------------------------
	// Count pulse generation
	// ----------------------------------------------------------------
	always_comb begin
		// event and config codes must match
		armed[0] = (sel_a[31:bqa_pkg::SEL_CODE_LO] == bqa_pkg::SEL_CODE) &&
			(cfg_a[bqa_pkg::CFG_SEL_LO +: 3] == bqa_pkg::CFG_SEL);
		armed[1] = (sel_b[31:bqa_pkg::SEL_CODE_LO] == bqa_pkg::SEL_CODE) &&
			(cfg_b[bqa_pkg::CFG_SEL_LO +: 3] == bqa_pkg::CFG_SEL);
		edge_mode[0] = cfg_a[bqa_pkg::CFG_EDGE];
		edge_mode[1] = cfg_b[bqa_pkg::CFG_EDGE];
		next_hit_prev = alloc_vld ? (hit & armed) : 2'h0;
		// select a to counters 0,1; b to 2,3
		next_cnt_pulse = 4'h0;
		for (int i = 0; i < 2; i++) begin
			if (alloc_vld && hit[i] && armed[i] &&
			    !(edge_mode[i] && hit_prev[i])) begin
				next_cnt_pulse[2*i]   = 1'b1;
				next_cnt_pulse[2*i+1] = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave: one wait state, error on unmapped address
	// ----------------------------------------------------------------
	always_comb begin
		access       = psel && penable && !pready;
		next_sel_a   = sel_a;
		next_sel_b   = sel_b;
		next_cfg_a   = cfg_a;
		next_cfg_b   = cfg_b;
		next_model   = model;
		next_prdata  = 32'h0000_0000;
		next_pready  = access;
		next_pslverr = 1'b0;
		// Hardware set wins over software clear of status
		next_match_seen = match_seen;
		mapped = 1'b1;
		unique case (paddr)
			bqa_pkg::OFS_SEL_A: next_prdata = sel_a;
			bqa_pkg::OFS_SEL_B: next_prdata = sel_b;
			bqa_pkg::OFS_CFG_A: next_prdata = cfg_a;
			bqa_pkg::OFS_CFG_B: next_prdata = cfg_b;
			bqa_pkg::OFS_MODEL: next_prdata = {28'h0000000, model};
			bqa_pkg::OFS_STAT:  next_prdata = {28'h0000000, match_seen};
			default:            mapped = 1'b0;
		endcase
		if (!access) begin
			next_prdata = 32'h0000_0000;
		end else if (!mapped) begin
			next_pslverr = 1'b1;
			next_prdata  = 32'h0000_0000;
		end else if (pwrite) begin
			next_prdata = 32'h0000_0000;
		end
		// Write lands only on the edge that completes the transfer
		if (psel && penable && pready && pwrite) begin
			unique case (paddr)
				bqa_pkg::OFS_SEL_A: next_sel_a = pwdata;
				bqa_pkg::OFS_SEL_B: next_sel_b = pwdata;
				bqa_pkg::OFS_CFG_A: next_cfg_a = pwdata;
				bqa_pkg::OFS_CFG_B: next_cfg_b = pwdata;
				bqa_pkg::OFS_MODEL: next_model = pwdata[3:0];
				bqa_pkg::OFS_STAT:  next_match_seen = match_seen & ~pwdata[3:0];
				default:            next_model = model;
			endcase
		end
		next_match_seen = next_match_seen | next_cnt_pulse;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sel_a      <= bqa_pkg::RST_SEL;
			sel_b      <= bqa_pkg::RST_SEL;
			cfg_a      <= bqa_pkg::RST_CFG;
			cfg_b      <= bqa_pkg::RST_CFG;
			model      <= bqa_pkg::RST_MODEL;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			cnt_pulse  <= 4'h0;
			hit_prev   <= 2'h0;
			match_seen <= 4'h0;
		end else begin
			sel_a      <= next_sel_a;
			sel_b      <= next_sel_b;
			cfg_a      <= next_cfg_a;
			cfg_b      <= next_cfg_b;
			model      <= next_model;
			prdata     <= next_prdata;
			pready     <= next_pready;
			pslverr    <= next_pslverr;
			cnt_pulse  <= next_cnt_pulse;
			hit_prev   <= next_hit_prev;
			match_seen <= next_match_seen;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	pair_a_a: assert property (@(posedge sys_clk) disable iff (rst)
		cnt_pulse[0] == cnt_pulse[1] && cnt_pulse[2] == cnt_pulse[3])
		else $error("counter pair pulses differ");
	code_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		!armed[0] |=> !cnt_pulse[0])
		else $error("pulse without correct codes");
	and_form_a: assert property (@(posedge sys_clk) disable iff (rst)
		(alloc_vld && armed[0] && and_form &&
		 !(is_read & sel_a[bqa_pkg::MASK_LO+bqa_pkg::M_ALL_RD]) &&
		 !(is_write & sel_a[bqa_pkg::MASK_LO+bqa_pkg::M_ALL_WR]))
		|=> !cnt_pulse[0])
		else $error("AND form counted without rw term");
	src_a: assert property (@(posedge sys_clk) disable iff (rst)
		(alloc_vld && own_agent && !sel_a[bqa_pkg::MASK_LO+bqa_pkg::M_OWN])
		|=> !cnt_pulse[0])
		else $error("own agent counted while deselected");
	pf_excl_a: assert property (@(posedge sys_clk) disable iff (rst)
		(alloc_vld && is_read && prefetch &&
		 !sel_a[bqa_pkg::MASK_LO+bqa_pkg::M_PREFETCH]) |=> !cnt_pulse[0])
		else $error("prefetch read counted");
	no_alloc_a: assert property (@(posedge sys_clk) disable iff (rst)
		!alloc_vld |=> cnt_pulse == 4'h0)
		else $error("pulse without allocation");
	edge_once_a: assert property (@(posedge sys_clk) disable iff (rst)
		(edge_mode[0] && $stable(cfg_a)) |-> !(cnt_pulse[0] && $past(cnt_pulse[0])))
		else $error("edge mode counted twice");
	status_a: assert property (@(posedge sys_clk) disable iff (rst)
		cnt_pulse[0] |-> match_seen[0])
		else $error("status missed a pulse");
	apb_rdy_a: assert property (@(posedge sys_clk) disable iff (rst)
		(psel && penable && !pready) |=> pready)
		else $error("apb answer late");
endmodule : bqa_top
`default_nettype wire
